// ==== hdl/port_j_pkg.sv ====
// Constants for the port J override block: register map, field places,
// reset values, pin and segment mapping.
// Assumes a 32-bit AXI4-Lite register bus with five address bits.
// ----------------------------------------------------------------
// Behaviour
// - Port bits 6..0 feed pin-change sources 30 down to 24.
// - Bits 6..2 drive segments 27..31, bit 1 segment 34, bit 0 segment 35.
// - LCD enable set forces every pin's pull-up off, ignoring port data.
// - LCD enable set forces direction to zero, output driver off.
// - Input-enable override only when mask, group enable, LCD enable, pin mode all set.
// - Each pin's analog path connects to its LCD segment driver output.
// ----------------------------------------------------------------
package port_j_pkg;
    localparam int          NPINS      = 7;
    localparam int          ADDR_W     = 5;
    localparam int          SRC_LO     = 24;
    localparam int          SRC_HI     = 30;
    localparam int          SEGMENT_LO = 27;
    localparam int          SEGMENT_HI = 35;
    // Segment number served by each port bit, index is the bit
    localparam int          SEGMENT_OF_BIT [NPINS] = '{35, 34, 31, 30, 29, 28, 27};
    // Register offsets
    localparam logic [4:0]  CTRL_ADDR  = 5'h00;
    localparam logic [4:0]  MASK_ADDR  = 5'h04;
    localparam logic [4:0]  STAT_ADDR  = 5'h08;
    // Control fields
    localparam int          CTRL_LCD_EN = 0;
    localparam int          CTRL_PMODE = 1;
    localparam int          CTRL_GRPEN = 2;
    localparam logic [2:0]  CTRL_RST   = 3'h0;
    localparam logic [6:0]  MASK_RST   = 7'h00;
    // Status fields
    localparam int          STAT_DIE_LO = 0;
    localparam int          STAT_PIN_LO = 8;
    localparam int          STAT_OVR    = 16;
    // Fixed override values
    localparam logic        PU_OVR_VAL  = 1'b0;
    localparam logic        DIR_OVR_VAL = 1'b0;
    localparam logic        PV_OVR_EN   = 1'b0;
    localparam logic        PV_OVR_VAL  = 1'b0;
    localparam logic        IE_OVR_VAL  = 1'b0;
    // Bus responses
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : port_j_pkg

// ==== hdl/port_j_cfg_if.sv ====
// Interface between the register slave and the override core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface port_j_cfg_if;
    logic        lcd_enable_bit;
    logic        lcd_pin_mode_bit;
    logic        pin_change_group_enable;
    logic [6:0]  pin_change_mask;
    logic [31:0] status;

    modport regs (output lcd_enable_bit, lcd_pin_mode_bit, pin_change_group_enable,
                  output pin_change_mask, input status);
    modport core (input lcd_enable_bit, lcd_pin_mode_bit, pin_change_group_enable,
                  input pin_change_mask, output status);
endinterface : port_j_cfg_if
`default_nettype wire

// ==== hdl/port_j_regs.sv ====
// AXI4-Lite slave holding control and mask, returning core status.
// Assumes one outstanding write and one outstanding read from the master.
`timescale 1ns/1ps
`default_nettype none
module port_j_regs (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    port_j_cfg_if.regs       cfg
);
    logic [2:0]  ctrl;
    logic [2:0]  next_ctrl;
    logic [6:0]  mask;
    logic [6:0]  next_mask;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [1:0]  next_rresp;
    logic [31:0] next_rdata;
    logic        wr_go;
    logic        rd_go;

    // Address and data are taken together; a lone one waits for its mate
    assign awready = awvalid && wvalid && !bvalid;
    assign wready  = awready;
    assign wr_go   = awready;
    assign arready = !rvalid;
    assign rd_go   = arvalid && arready;

    // ----------------------------------------------------------------
    // Write and read next-state
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl   = ctrl;
        next_mask   = mask;
        next_bvalid = bvalid && !bready;
        next_bresp  = bresp;
        next_rvalid = rvalid && !rready;
        next_rresp  = rresp;
        next_rdata  = rdata;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp  = port_j_pkg::RESP_OKAY;
            case (awaddr)
                port_j_pkg::CTRL_ADDR: if (wstrb[0]) next_ctrl = wdata[2:0];
                port_j_pkg::MASK_ADDR: if (wstrb[0]) next_mask = wdata[6:0];
                port_j_pkg::STAT_ADDR: next_bresp = port_j_pkg::RESP_OKAY; // Read-only, write dropped
                default:               next_bresp = port_j_pkg::RESP_SLVERR;
            endcase
        end
        if (rd_go) begin
            next_rvalid = 1'b1;
            next_rresp  = port_j_pkg::RESP_OKAY;
            case (araddr)
                port_j_pkg::CTRL_ADDR: next_rdata = {29'h0, ctrl};
                port_j_pkg::MASK_ADDR: next_rdata = {25'h0, mask};
                port_j_pkg::STAT_ADDR: next_rdata = cfg.status;
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = port_j_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl   <= port_j_pkg::CTRL_RST;
            mask   <= port_j_pkg::MASK_RST;
            bvalid <= 1'b0;
            bresp  <= port_j_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp  <= port_j_pkg::RESP_OKAY;
            rdata  <= 32'h0;
        end else begin
            ctrl   <= next_ctrl;
            mask   <= next_mask;
            bvalid <= next_bvalid;
            bresp  <= next_bresp;
            rvalid <= next_rvalid;
            rresp  <= next_rresp;
            rdata  <= next_rdata;
        end
    end

    assign cfg.lcd_enable_bit          = ctrl[port_j_pkg::CTRL_LCD_EN];
    assign cfg.lcd_pin_mode_bit        = ctrl[port_j_pkg::CTRL_PMODE];
    assign cfg.pin_change_group_enable = ctrl[port_j_pkg::CTRL_GRPEN];
    assign cfg.pin_change_mask         = mask;
endmodule : port_j_regs
`default_nettype wire

// ==== hdl/port_j_lcd_pinchange_override.sv ====
// Port J alternate-function override: pin-change sources and LCD segments
// on seven pins, with the pad controls taken over while the LCD runs.
// Assumes port data and direction come from logic on aclk, pads and pin
// inputs are asynchronous, and the LCD controller drives segments on aclk.
`timescale 1ns/1ps
`default_nettype none
module port_j_lcd_pinchange_override (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Ordinary port registers
    input  wire logic [6:0]  port_data,
    input  wire logic [6:0]  port_dir,
    // Pads
    input  wire logic [6:0]  pin_in,
    output logic [6:0]       pin_out,
    output logic [6:0]       pin_oe_n,
    output logic [6:0]       pullup_on,
    // LCD controller front-plane drive, indexed by segment number
    input  wire logic [35:27] lcd_segment_drive,
    output logic [6:0]       analog_pin_path,
    // Pin-change interrupt logic
    output logic [30:24]     pin_change_src,
    // Override signals as seen by the port logic
    output logic             pullup_override_enable,
    output logic             direction_override_enable,
    output logic             port_value_override_enable,
    output logic [6:0]       input_enable_override_enable
);

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    port_j_cfg_if cfg ();

    port_j_regs u_regs (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .cfg     (cfg)
    );

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    logic [6:0] pin_meta;
    logic [6:0] pin_sync;
    logic [6:0] next_pin_meta;
    logic [6:0] next_pin_sync;

    // Two stages; only the second stage feeds any logic
    always_comb begin
        next_pin_meta = pin_in;
        next_pin_sync = pin_meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 7'h00;
            pin_sync <= 7'h00;
        end else begin
            pin_meta <= next_pin_meta;
            pin_sync <= next_pin_sync;
        end
    end

    // ----------------------------------------------------------------
    // Override terms
    // ----------------------------------------------------------------
    logic       lcd_on;
    logic [6:0] die_ovr;
    logic [6:0] segment_sel;

    assign lcd_on = cfg.lcd_enable_bit;

    // Per-bit input-enable override and segment pick
    generate
        for (genvar i = 0; i < port_j_pkg::NPINS; i++) begin : g_bit
            // All four conditions must hold; any one clear releases the input
            assign die_ovr[i] = cfg.pin_change_mask[i] &
                                cfg.pin_change_group_enable &
                                lcd_on &
                                cfg.lcd_pin_mode_bit;
            assign segment_sel[i] = lcd_segment_drive[port_j_pkg::SEGMENT_OF_BIT[i]];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next pad and override values
    // ----------------------------------------------------------------
    logic [6:0]  next_pin_out;
    logic [6:0]  next_pin_oe_n;
    logic [6:0]  next_pullup_on;
    logic [6:0]  next_analog;
    logic [6:0]  next_src;
    logic        next_pu_ovr_en;
    logic        next_dir_ovr_en;
    logic        next_pv_ovr_en;
    logic [6:0]  next_ie_ovr_en;
    logic [6:0]  dir_eff;
    logic [31:0] next_status;
    logic [31:0] status;

    // Everything is registered once, so pads lag the controls by a cycle;
    // this keeps data outputs glitch-free at the cost of one cycle.
    always_comb begin
        next_pu_ovr_en  = lcd_on;
        next_dir_ovr_en = lcd_on;
        next_pv_ovr_en  = port_j_pkg::PV_OVR_EN;
        next_ie_ovr_en  = die_ovr;
        // With LCD off, pull-up is on for an input pin with its data bit set
        next_pullup_on = lcd_on ? {7{port_j_pkg::PU_OVR_VAL}}
                                : (port_data & ~port_dir);
        dir_eff        = lcd_on ? {7{port_j_pkg::DIR_OVR_VAL}} : port_dir;
        next_pin_oe_n  = ~dir_eff;
        // Value override stays off, so the data register always drives
        next_pin_out   = port_j_pkg::PV_OVR_EN ? {7{port_j_pkg::PV_OVR_VAL}} : port_data;
        next_analog    = segment_sel;
        // An overridden input enable forces the sampled level to its value
        next_src       = (die_ovr & {7{port_j_pkg::IE_OVR_VAL}}) |
                         (~die_ovr & pin_sync);
        next_status    = 32'h0;
        next_status[port_j_pkg::STAT_DIE_LO +: 7] = die_ovr;
        next_status[port_j_pkg::STAT_PIN_LO +: 7] = pin_sync;
        next_status[port_j_pkg::STAT_OVR]         = lcd_on;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out                      <= 7'h00;
            pin_oe_n                     <= 7'h7f;
            pullup_on                    <= 7'h00;
            analog_pin_path              <= 7'h00;
            pin_change_src               <= 7'h00;
            pullup_override_enable       <= 1'b0;
            direction_override_enable    <= 1'b0;
            port_value_override_enable   <= 1'b0;
            input_enable_override_enable <= 7'h00;
            status                       <= 32'h0;
        end else begin
            pin_out                      <= next_pin_out;
            pin_oe_n                     <= next_pin_oe_n;
            pullup_on                    <= next_pullup_on;
            analog_pin_path              <= next_analog;
            pin_change_src               <= next_src;
            pullup_override_enable       <= next_pu_ovr_en;
            direction_override_enable    <= next_dir_ovr_en;
            port_value_override_enable   <= next_pv_ovr_en;
            input_enable_override_enable <= next_ie_ovr_en;
            status                       <= next_status;
        end
    end

    assign cfg.status = status;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Source 30 follows bit 6, source 24 follows bit 0, when not overridden
    a_src_map_top: assert property (@(posedge aclk) disable iff (!aresetn)
        !die_ovr[6] |=> (pin_change_src[30] == $past(pin_sync[6])))
        else $error("pin-change source 30 does not follow bit 6");

    a_src_map_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !die_ovr[0] |=> (pin_change_src[24] == $past(pin_sync[0])))
        else $error("pin-change source 24 does not follow bit 0");

    a_seg_map: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn |=> (analog_pin_path[1] == $past(lcd_segment_drive[34])) &&
            (analog_pin_path[2] == $past(lcd_segment_drive[31])) &&
            (analog_pin_path[6] == $past(lcd_segment_drive[27])))
        else $error("segment to bit mapping wrong");

    a_pullup_off: assert property (@(posedge aclk) disable iff (!aresetn)
        lcd_on ##1 lcd_on |=> (pullup_on == 7'h00) && pullup_override_enable)
        else $error("pull-up on while LCD enabled");

    a_driver_off: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(lcd_on) |=> (pin_oe_n == 7'h7f) && direction_override_enable)
        else $error("output driver on while LCD enabled");

    a_die_and: assert property (@(posedge aclk) disable iff (!aresetn)
        (cfg.pin_change_mask[3] && cfg.pin_change_group_enable && lcd_on
         && cfg.lcd_pin_mode_bit) |=> input_enable_override_enable[3]
        ##0 !pin_change_src[27])
        else $error("input-enable override missing with all conditions set");

    a_die_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg.lcd_pin_mode_bit |=> (input_enable_override_enable == 7'h00))
        else $error("input-enable override set with pin mode clear");

    a_analog_path: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && $past(aresetn) && $changed(lcd_segment_drive[35])
        |=> (analog_pin_path[0] != $past(analog_pin_path[0])))
        else $error("analog path does not track segment 35");

    // The release edge itself is skipped: outputs then still hold reset values
    a_port_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && !lcd_on |=> (pin_oe_n == ~$past(port_dir)) && (pin_out == $past(port_data))
        && !port_value_override_enable
        && (pullup_on == ($past(port_data) & ~$past(port_dir))))
        else $error("port registers not in control with LCD off");

endmodule : port_j_lcd_pinchange_override
`default_nettype wire

// ==== dv/lcd_front_plane_model.sv ====
// LCD controller stand-in: drives front-plane segments 27..35 on aclk.
// Assumes the bench sets the wanted segment levels on segment_cmd.
`timescale 1ns/1ps
`default_nettype none
module lcd_front_plane_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [8:0]  segment_cmd,
    output logic [35:27]     lcd_segment_drive
);
    // ----------------------------------------------------------------
    // Segment drive
    // ----------------------------------------------------------------
    logic [35:27] next_drive;

    // Segments 32 and 33 have no pin here; toggling them exposes a wrong tap
    always_comb begin
        next_drive = segment_cmd;
        next_drive[33:32] = ~lcd_segment_drive[33:32];
    end

    // Blank while in reset, like a controller that is not yet running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lcd_segment_drive <= 9'h000;
        end else begin
            lcd_segment_drive <= next_drive;
        end
    end
endmodule : lcd_front_plane_model
`default_nettype wire

// ==== dv/port_j_lcd_pinchange_override_tb.sv ====
// Self-checking bench for the port J override block.
// Assumes the register map and latencies of the design package and notes.
`timescale 1ns/1ps
`default_nettype none
module port_j_lcd_pinchange_override_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        aclk, aresetn;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic [6:0]  port_data, port_dir, pin_in, pin_out, pin_oe_n, pullup_on;
    logic [6:0]  analog_pin_path, input_enable_override_enable;
    logic [35:27] lcd_segment_drive;
    logic [30:24] pin_change_src;
    logic        pullup_override_enable, direction_override_enable, port_value_override_enable;
    logic [8:0]  segment_cmd;
    int          err_total, n_tests;

    port_j_lcd_pinchange_override dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_data(port_data), .port_dir(port_dir), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .lcd_segment_drive(lcd_segment_drive),
        .analog_pin_path(analog_pin_path), .pin_change_src(pin_change_src),
        .pullup_override_enable(pullup_override_enable),
        .direction_override_enable(direction_override_enable),
        .port_value_override_enable(port_value_override_enable),
        .input_enable_override_enable(input_enable_override_enable));

    lcd_front_plane_model lcd_u (.aclk(aclk), .aresetn(aresetn), .segment_cmd(segment_cmd),
        .lcd_segment_drive(lcd_segment_drive));

    // Free-running 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic hang(input string what);
        err_total++;
        $display("ERROR t=%0t %s: no answer", $time, what);
        tally_and_finish();
    endtask : hang

    // Outputs lag inputs by 1 cycle, pins by 3; look between edges
    task automatic settle();
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    // Ready is sampled at the falling edge; inputs only move at rising edges
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge aclk);
            if (awready === 1'b1 && wready === 1'b1) break;
        end
        if (k == 64) hang("write address");
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        for (k = 0; k < 64; k++) begin
            @(negedge aclk);
            if (bvalid === 1'b1) break;
        end
        if (k == 64) hang("write response");
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(negedge aclk);
            if (arready === 1'b1) break;
        end
        if (k == 64) hang("read address");
        @(posedge aclk);
        arvalid <= 1'b0;
        for (k = 0; k < 64; k++) begin
            @(negedge aclk);
            if (rvalid === 1'b1) break;
        end
        if (k == 64) hang("read data");
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : axi_rd

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk(pin_oe_n, 32'h7f, "oe_n in reset");
        chk(input_enable_override_enable, 32'h0, "ie in reset");
        chk(pullup_override_enable, 32'h0, "pu ovr in reset");
        @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(port_j_pkg::CTRL_ADDR, d, r);
        chk(d, 32'h0, "ctrl reset value");
        axi_rd(port_j_pkg::MASK_ADDR, d, r);
        chk(d, 32'h0, "mask reset value");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(5'h0c, d, r);
        chk(d, 32'h0, "unmapped read data");
        chk(r, port_j_pkg::RESP_SLVERR, "unmapped read resp");
        axi_wr(5'h0c, 32'h7, 4'hf, r);
        chk(r, port_j_pkg::RESP_SLVERR, "unmapped write");
        axi_wr(port_j_pkg::CTRL_ADDR, 32'h1, 4'he, r);
        axi_rd(port_j_pkg::CTRL_ADDR, d, r);
        chk(d, 32'h0, "strobe low ignored");
        $display("t_regs done");
    endtask : t_regs

    // LCD off leaves the port registers in charge, then LCD on takes over
    task automatic t_lcd_takeover();
        logic [1:0] r;
        @(posedge aclk);
        port_data <= 7'h35;
        port_dir <= 7'h0f;
        settle();
        chk(pin_out, 32'h35, "off out");
        chk(pin_oe_n, 32'h70, "off oe_n");
        chk(pullup_on, 32'h30, "off pullup");
        axi_wr(port_j_pkg::CTRL_ADDR, 32'h1, 4'hf, r);
        chk(r, port_j_pkg::RESP_OKAY, "ctrl write");
        settle();
        chk(pullup_on, 32'h0, "on pullup");
        chk(pullup_override_enable, 32'h1, "on pu ovr");
        chk(pin_oe_n, 32'h7f, "on oe_n");
        chk(direction_override_enable, 32'h1, "on dir ovr");
        chk(port_value_override_enable, 32'h0, "on pv ovr");
        chk(pin_out, 32'h35, "on out");
        @(posedge aclk);
        port_data <= 7'h4a;
        port_dir <= 7'h00;
        settle();
        chk(pullup_on, 32'h0, "on pullup data");
        axi_wr(port_j_pkg::CTRL_ADDR, 32'h0, 4'hf, r);
        settle();
        chk(pullup_on, 32'h4a, "back off pullup");
        chk(pin_oe_n, 32'h7f, "back off oe_n");
        $display("t_lcd_takeover done");
    endtask : t_lcd_takeover

    // One segment at a time must reach exactly its own pin
    task automatic t_segments();
        int i;
        int s;
        for (i = 0; i < 7; i++) begin
            s = (i >= 2) ? 33 - i : 35 - i;
            @(posedge aclk);
            segment_cmd <= 9'h001 << (s - 27);
            settle();
            chk(analog_pin_path, 32'h1 << i, "segment to pin");
        end
        $display("t_segments done");
    endtask : t_segments

    task automatic t_pin_change();
        int i;
        for (i = 0; i < 7; i++) begin
            @(posedge aclk);
            pin_in <= 7'h01 << i;
            settle();
            chk(pin_change_src, 32'h1 << i, "pin to source");
        end
        $display("t_pin_change done");
    endtask : t_pin_change

    // Every control combination; only all four set lifts the input override
    task automatic t_input_enable();
        logic [31:0] d;
        logic [1:0]  r;
        logic [6:0]  e;
        int          c;
        @(posedge aclk);
        pin_in <= 7'h7f;
        axi_wr(port_j_pkg::MASK_ADDR, 32'h7f, 4'hf, r);
        for (c = 0; c < 8; c++) begin
            axi_wr(port_j_pkg::CTRL_ADDR, c, 4'hf, r);
            settle();
            e = (c == 7) ? 7'h7f : 7'h00;
            chk(input_enable_override_enable, e, "ie combo");
            chk(pin_change_src, e ^ 7'h7f, "src forced");
        end
        axi_wr(port_j_pkg::MASK_ADDR, 32'h55, 4'hf, r);
        axi_wr(port_j_pkg::STAT_ADDR, 32'h0, 4'hf, r);
        chk(r, port_j_pkg::RESP_OKAY, "stat write");
        settle();
        chk(input_enable_override_enable, 32'h55, "ie mask");
        chk(pin_change_src, 32'h2a, "src mask");
        axi_rd(port_j_pkg::STAT_ADDR, d, r);
        chk(d, 32'h00017f55, "status");
        $display("t_input_enable done");
    endtask : t_input_enable

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        err_total = 0;
        n_tests = 0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
        {port_data, port_dir, pin_in, segment_cmd} = '0;
        t_reset();
        t_regs();
        t_lcd_takeover();
        t_segments();
        t_pin_change();
        t_input_enable();
        t_reset();
        tally_and_finish();
    end
endmodule : port_j_lcd_pinchange_override_tb
`default_nettype wire
